// ===== shared/sbst_cfg.svh
// Purpose: constants of the memory test access port
// Assumes: included by package and design files
// Notes:   instruction codes, id fields, sizes
`ifndef SBST_CFG_SVH
`define SBST_CFG_SVH

`define SBST_IR_WIDTH        3
`define SBST_ID_WIDTH        32
`define SBST_BSR_WIDTH       70
`define SBST_INS_EXTEST      3'h0
`define SBST_INS_IDCODE      3'h1
`define SBST_INS_SAMPLEZ     3'h2
`define SBST_INS_SAMPLE      3'h4
`define SBST_INS_BYPASS      3'h7
`define SBST_IR_CAPTURE      2'h1
`define SBST_ID_REVISION     3'h0
`define SBST_ID_DEPARTMENT   3'h5
`define SBST_ID_VOLTAGE      2'h0
`define SBST_ID_ARCH         3'h1
`define SBST_ID_MEMTYPE      3'h0
`define SBST_ID_WIDTH_X18    3'h2
`define SBST_ID_WIDTH_X36    3'h4
`define SBST_ID_WIDTH_X72    3'h6
`define SBST_ID_DENSITY      3'h4
// vendor code is an arbitrary neutral value
`define SBST_ID_VENDOR       11'h2A5
`define SBST_ID_PRESENT      1'h1
`define SBST_RESET_TMS_EDGES 3'h5

`endif

// ===== shared/sbst_pkg.sv
// Purpose: types of the memory test access port
// Assumes: sbst_cfg.svh available on the include path
// Notes:   timing counts live in the header
`include "sbst_cfg.svh"

package sbst_pkg;

   typedef enum logic [3:0] {
      TEST_LOGIC_RESET, RUN_TEST_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
      PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR,
      PAUSE_IR, EXIT2_IR, UPDATE_IR
   } sbst_tap_e;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } sbst_pins_s;

   typedef struct packed {
      logic tdo;
      logic tdoEn;
   } sbst_tdo_s;

endpackage

// ===== design/sbst_sync.sv
// Purpose: two-flop synchroniser for the test pins
// Assumes: inputs asynchronous to clk
// Notes:   first stage read only by the second
`timescale 1ns/1ps
`default_nettype none

module sbst_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sbst_sync_s;

   sbst_sync_s state_q;
   sbst_sync_s state_d;

   always_comb begin
      state_d      = state_q;
      state_d.meta = asyncIn;
      state_d.sync = state_q.meta;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign syncOut = state_q.sync;

endmodule

`default_nettype wire

// ===== design/sbst_tap.sv
// Purpose: boundary-scan test port of a pipelined memory
// Assumes: test clock sampled by clk, far slower than clk
// Notes:   pin ring arrives as a parallel vector from the memory core
//
// Functional notes
// - code 000 captures pin ring, selects scan register, floats memory outputs
// - code 001 captures id value and selects it, memory unaffected
// - code 010 captures ring, selects scan register, floats memory outputs
// - code 100 captures ring, selects scan register, no preload, memory unaffected
// - code 111 selects one-bit bypass, memory unaffected
// - update-dr under sample changes nothing, like pause-dr
// - after capture, shift-dr shifts scan register out
// - bypass in shift-dr gives one-stage path from input to output
// - id bit 0 always reads one
// - id fields hardwired at their documented positions
// - width field gives distinct code per data-width configuration
// - five high mode-select edges reset the port, memory undisturbed
// - power-up and test-logic reset load the id instruction
// - capture-ir loads 01 into the two low instruction bits
// - inputs sampled on rising test-clock edges, output on falling
`timescale 1ns/1ps
`default_nettype none
`include "sbst_cfg.svh"

module sbst_tap #(
   parameter int         BSR_WIDTH = `SBST_BSR_WIDTH,
   parameter logic [1:0] DATA_CFG  = 2'h1
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire sbst_pkg::sbst_pins_s testPins,
   input  wire logic [BSR_WIDTH-1:0] pinRing,
   output sbst_pkg::sbst_tdo_s       testOut,
   output logic                      memOutDisable,
   output logic [2:0]                activeInstr
);
   import sbst_pkg::*;

   // a bit-select needs a named constant, not a bare literal
   localparam logic [1:0] ID_VOLT = `SBST_ID_VOLTAGE;

   typedef struct packed {
      sbst_tap_e            tap;
      logic                 tckLast;
      logic [2:0]           irShift;
      logic [2:0]           irActive;
      logic                 bypass;
      logic [31:0]          idShift;
      logic [BSR_WIDTH-1:0] bsr;
      logic                 tdo;
      logic                 tdoEn;
      logic                 hiZ;
   } sbst_state_s;

   sbst_state_s state_q;
   sbst_state_s state_d;
   logic [2:0]  pinSync;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        rise;
   logic        fall;
   logic [2:0]  widthCode;
   logic [31:0] idValue;
   logic        serialOut;

   sbst_sync #(
      .WIDTH(3)
   ) u_sync (
      .clk    (clk),
      .reset_n(reset_n),
      .asyncIn({testPins.tck, testPins.tms, testPins.tdi}),
      .syncOut(pinSync)
   );

   assign tck  = pinSync[2];
   assign tms  = pinSync[1];
   assign tdi  = pinSync[0];
   assign rise = tck & ~state_q.tckLast;
   assign fall = ~tck & state_q.tckLast;

   always_comb begin
      unique case (DATA_CFG)
         2'h0:    widthCode = `SBST_ID_WIDTH_X18;
         2'h1:    widthCode = `SBST_ID_WIDTH_X36;
         default: widthCode = `SBST_ID_WIDTH_X72;
      endcase
   end

   // vendor field is an arbitrary neutral value
   assign idValue = {`SBST_ID_REVISION, ID_VOLT[1], `SBST_ID_DEPARTMENT, ID_VOLT[0],
                     `SBST_ID_ARCH, `SBST_ID_MEMTYPE, widthCode, `SBST_ID_DENSITY,
                     `SBST_ID_VENDOR, `SBST_ID_PRESENT};

   always_comb begin
      if (state_q.tap == SHIFT_IR) begin
         serialOut = state_q.irShift[0];
      end else begin
         unique case (state_q.irActive)
            `SBST_INS_IDCODE: serialOut = state_q.idShift[0];
            `SBST_INS_EXTEST,
            `SBST_INS_SAMPLEZ,
            `SBST_INS_SAMPLE: serialOut = state_q.bsr[0];
            default:          serialOut = state_q.bypass;
         endcase
      end
   end

   always_comb begin
      state_d         = state_q;
      state_d.tckLast = tck;
      if (rise) begin
         unique case (state_q.tap)
            TEST_LOGIC_RESET: state_d.tap = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE:    state_d.tap = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR:        state_d.tap = tms ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR:       state_d.tap = tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:         state_d.tap = tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:         state_d.tap = tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR:         state_d.tap = tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:         state_d.tap = tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR:        state_d.tap = tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR:        state_d.tap = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR:       state_d.tap = tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:         state_d.tap = tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:         state_d.tap = tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR:         state_d.tap = tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:         state_d.tap = tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR:        state_d.tap = tms ? SELECT_DR : RUN_TEST_IDLE;
         endcase
         unique case (state_q.tap)
            TEST_LOGIC_RESET: state_d.irActive = `SBST_INS_IDCODE;
            CAPTURE_IR:       state_d.irShift = {state_q.irActive[2], `SBST_IR_CAPTURE};
            SHIFT_IR:         state_d.irShift = {tdi, state_q.irShift[2:1]};
            UPDATE_IR:        state_d.irActive = state_q.irShift;
            CAPTURE_DR: begin
               unique case (state_q.irActive)
                  `SBST_INS_IDCODE: state_d.idShift = idValue;
                  `SBST_INS_EXTEST,
                  `SBST_INS_SAMPLEZ,
                  `SBST_INS_SAMPLE: state_d.bsr = pinRing;
                  default:          state_d.bypass = 1'b0;
               endcase
            end
            SHIFT_DR: begin
               unique case (state_q.irActive)
                  `SBST_INS_IDCODE: state_d.idShift = {tdi, state_q.idShift[31:1]};
                  `SBST_INS_EXTEST,
                  `SBST_INS_SAMPLEZ,
                  `SBST_INS_SAMPLE: state_d.bsr = {tdi, state_q.bsr[BSR_WIDTH-1:1]};
                  default:          state_d.bypass = tdi;
               endcase
            end
            // no preload latch exists, so update-dr leaves every register alone
            UPDATE_DR:        state_d.bsr = state_q.bsr;
            default:          state_d.tap = state_d.tap;
         endcase
         // load on entry, so the fifth high edge resets from any state
         if (state_d.tap == TEST_LOGIC_RESET) begin
            state_d.irActive = `SBST_INS_IDCODE;
         end
      end
      if (fall) begin
         state_d.tdoEn = (state_q.tap == SHIFT_DR) || (state_q.tap == SHIFT_IR);
         // output held outside the shift states
         if (state_d.tdoEn) begin
            state_d.tdo = serialOut;
         end
      end
      // reserved codes float nothing; only the two capture-with-float codes do
      state_d.hiZ = (state_d.irActive == `SBST_INS_EXTEST) || (state_d.irActive == `SBST_INS_SAMPLEZ);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_q          <= '0;
         state_q.tap      <= TEST_LOGIC_RESET;
         state_q.irActive <= `SBST_INS_IDCODE;
         state_q.irShift  <= `SBST_INS_IDCODE;
      end else begin
         state_q <= state_d;
      end
   end

   assign testOut       = '{tdo: state_q.tdo, tdoEn: state_q.tdoEn};
   assign memOutDisable = state_q.hiZ;
   assign activeInstr   = state_q.irActive;

endmodule

`default_nettype wire

// ===== verification/sbst_tap_asserts.sv
// Purpose: port checks of the test port
// Assumes: one clk domain, bound from the bench
// Notes:   tck edges seen on the raw pin, so slack covers the synchroniser
`timescale 1ns/1ps
`default_nettype none
module sbst_tap_asserts #(
   parameter int BSR_WIDTH = 70
) (
   input wire logic                 clk,
   input wire logic                 reset_n,
   input wire sbst_pkg::sbst_pins_s testPins,
   input wire logic [BSR_WIDTH-1:0] pinRing,
   input wire sbst_pkg::sbst_tdo_s  testOut,
   input wire logic                 memOutDisable,
   input wire logic [2:0]           activeInstr
);
   import sbst_pkg::*;
   logic       tckPrev_q;
   logic [2:0] tmsRuns_q;
   // counts tck rises with tms high, saturating so a long run stays armed
   always_ff @(posedge clk) begin
      tckPrev_q <= testPins.tck;
      if (!reset_n) begin
         tmsRuns_q <= 3'h0;
      end else if (testPins.tck && !tckPrev_q) begin
         tmsRuns_q <= !testPins.tms ? 3'h0 : (tmsRuns_q == 3'h5 ? 3'h5 : tmsRuns_q + 3'h1);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence fiveHigh;
      $rose(tmsRuns_q == 3'h5);
   endsequence
   sequence instrSteady;
      $stable(activeInstr) [*2];
   endsequence
   reset_instr_a: assert property (disable iff (1'b0) !reset_n |=> activeInstr == 3'h1)
      else $error("instruction not id after reset");
   tap_reset_a: assert property (fiveHigh |-> ##[1:8] activeInstr == 3'h1)
      else $error("five tms rises did not reset");
   float_map_a: assert property (instrSteady |-> memOutDisable == (activeInstr inside {3'h0, 3'h2}))
      else $error("float does not match instruction");
   tdo_fall_a: assert property ($changed(testOut.tdo) |-> !testPins.tck)
      else $error("tdo moved while tck high");
   enable_fall_a: assert property ($changed(testOut.tdoEn) |-> !testPins.tck)
      else $error("tdo enable moved while tck high");
   instr_rise_a: assert property ($changed(activeInstr) |-> testPins.tck)
      else $error("instruction moved while tck low");
   float_rise_a: assert property ($changed(memOutDisable) |-> testPins.tck)
      else $error("float moved while tck low");
   idle_hold_a: assert property (!testOut.tdoEn && !$past(testOut.tdoEn) |-> $stable(testOut.tdo))
      else $error("tdo moved outside shift");
endmodule
`default_nettype wire

// ===== verification/sbst_ctrl_model.sv
// Purpose: behavioural boundary-scan controller
// Assumes: tck made from clk, 40 ns high and 40 ns low
// Notes:   tms and tdi start high like the pin pull-ups
`timescale 1ns/1ps
`default_nettype none
module sbst_ctrl_model (
   input  wire logic           clk,
   output var sbst_pkg::sbst_pins_s testPins,
   input  wire logic           tdo
);
   import sbst_pkg::*;
   initial testPins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
   // one tck period; tdo read late in the low phase, just before the rise
   task automatic pulse(input logic m, input logic d, output logic o);
      @(negedge clk);
      testPins.tms = m;
      testPins.tdi = d;
      repeat (4) @(negedge clk);
      o = tdo;
      testPins.tck = 1'b1;
      repeat (5) @(negedge clk);
      testPins.tck = 1'b0;
      testPins.tdi = ~d; // hold is over: no stale value left
   endtask
endmodule
`default_nettype wire

// ===== verification/sbst_tap_bench.sv
// Purpose: self-checking bench of the test port
// Assumes: controller model drives the pins
// Notes:   expectations built from the shared constants
`timescale 1ns/1ps
`default_nettype none
`include "sbst_cfg.svh"
module sbst_tap_bench;
   import sbst_pkg::*;
   localparam int BW = 70;
   localparam logic [1:0] VOLT = `SBST_ID_VOLTAGE;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [BW-1:0] pinRing = '0;
   sbst_pins_s testPins;
   sbst_tdo_s  testOut;
   logic       memOutDisable;
   logic [2:0] activeInstr;
   int         errors = 0;
   int         num_checks = 0;
   int         cycles = 0;
   always #4 clk = ~clk;
   sbst_tap #(.BSR_WIDTH(BW), .DATA_CFG(2'h1)) sbst_tap_inst (.clk(clk), .reset_n(reset_n), .testPins(testPins),
      .pinRing(pinRing), .testOut(testOut), .memOutDisable(memOutDisable), .activeInstr(activeInstr));
   sbst_ctrl_model sbst_ctrl_model_inst (.clk(clk), .testPins(testPins), .tdo(testOut.tdo));
   task automatic check(input logic [BW-1:0] seen, input logic [BW-1:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic walk(input logic [7:0] ms, input int n);
      logic o;
      for (int i = 0; i < n; i++) sbst_ctrl_model_inst.pulse(ms[i], 1'b1, o);
   endtask
   // from idle: capture, shift n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [BW-1:0] din, output logic [BW-1:0] dout);
      logic o;
      dout = '0;
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (int i = 0; i < n; i++) begin
         sbst_ctrl_model_inst.pulse(i == n - 1, din[i], o);
         dout[i] = o;
      end
      walk(8'h01, 2);
   endtask
   task automatic id_read();
      logic [BW-1:0] q;
      scan(1'b0, 32, '0, q);
      check(q, BW'({`SBST_ID_REVISION, VOLT[1], `SBST_ID_DEPARTMENT, VOLT[0], `SBST_ID_ARCH, `SBST_ID_MEMTYPE,
         `SBST_ID_WIDTH_X36, `SBST_ID_DENSITY, `SBST_ID_VENDOR, 1'b1}));
   endtask
   task automatic instr_set();
      logic [BW-1:0] q;
      logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h4, 3'h1, 3'h7}; // reserved codes never loaded
      foreach (codes[i]) begin
         scan(1'b1, 3, BW'(codes[i]), q);
         check(BW'(q[1:0]), BW'(2'h1));
         check(BW'(activeInstr), BW'(codes[i]));
         check(BW'(memOutDisable), BW'(codes[i] inside {3'h0, 3'h2}));
      end
   endtask
   task automatic bypass_path();
      logic [BW-1:0] q;
      scan(1'b0, 8, BW'(8'hB5), q);
      check(q, BW'(8'(8'hB5 << 1)));
   endtask
   task automatic tap_reset();
      // start in shift-dr, one of the states five edges from reset
      walk(8'h01, 3);
      walk(8'h1F, 5);
      check(BW'(activeInstr), BW'(`SBST_INS_IDCODE));
      walk(8'h00, 1);
   endtask
   task automatic sample_ring();
      logic [BW-1:0] q;
      logic [BW-1:0] ring;
      ring = {35{2'h2}} ^ BW'(16'hF00D);
      scan(1'b1, 3, BW'(`SBST_INS_SAMPLE), q);
      // ring held steady through capture, so no bit has to be ignored
      pinRing = ring;
      scan(1'b0, BW, '1, q);
      check(q, ring);
      check(BW'({activeInstr, memOutDisable}), BW'(4'h8));
      pinRing = ~ring;
      scan(1'b0, BW, '0, q);
      check(q, ~ring);
   endtask
   task automatic reset_midrun();
      logic [BW-1:0] q;
      scan(1'b1, 3, BW'(`SBST_INS_SAMPLEZ), q);
      check(BW'(memOutDisable), BW'(1'b1));
      reset_n = 1'b0;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      check(BW'({activeInstr, testOut.tdoEn, memOutDisable}), BW'(5'h4));
      walk(8'h00, 1);
   endtask
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      check(BW'({activeInstr, testOut.tdoEn, memOutDisable}), BW'(5'h4));
      walk(8'h00, 1);
      id_read();
      instr_set();
      bypass_path();
      tap_reset();
      sample_ring();
      reset_midrun();
      complete_run();
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         complete_run();
      end
   end
endmodule
bind sbst_tap sbst_tap_asserts #(.BSR_WIDTH(BSR_WIDTH)) sbst_tap_asserts_inst (.clk(clk), .reset_n(reset_n),
   .testPins(testPins), .pinRing(pinRing), .testOut(testOut), .memOutDisable(memOutDisable),
   .activeInstr(activeInstr));
`default_nettype wire
